// [include/sep_pkg.sv]
// Shared constants and types for the two-wire EEPROM slave port and its
// bus master. Assumes a 20 MHz system clock on both ends.
package sep_pkg;
    // Clock and timing
    localparam int CLK_KHZ   = 20000;
    localparam int NOISE_NS  = 100;
    localparam int NOISE_CYC = (NOISE_NS * CLK_KHZ) / 1000000;
    localparam int POWERUP_READY_DELAY_US  = 1000;
    localparam int POWERUP_READY_DELAY_CYC =
        (POWERUP_READY_DELAY_US * CLK_KHZ) / 1000;
    localparam int INTERNAL_WRITE_TIME_US  = 5000;
    localparam int INTERNAL_WRITE_TIME_CYC =
        (INTERNAL_WRITE_TIME_US * CLK_KHZ) / 1000;
    localparam int SCL_KHZ   = 100;
    localparam int QTR_CYC   = CLK_KHZ / (4 * SCL_KHZ);
    localparam int CNT_W     = 20;
    // Frame layout
    localparam int       MEM_AW   = 8;
    localparam int       MEM_SIZE = 256;
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam logic [3:0] ACK_POS  = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // Master register map (byte addresses)
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_DEVSEL = 8'h04;
    localparam logic [7:0] REG_WADDR  = 8'h08;
    localparam logic [7:0] REG_WDATA  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // Field positions
    localparam int CMD_WR      = 0;
    localparam int CMD_RD      = 1;
    localparam int ST_BUSY     = 0;
    localparam int ST_NACK     = 1;
    localparam int ST_RDATA_LO = 8;
    // Byte kinds seen by the slave
    typedef enum logic [1:0] {
        K_SLA  = 2'h0,
        K_WORD = 2'h1,
        K_DATA = 2'h2
    } sep_kind_t;
    typedef enum logic [4:0] {
        D_IDLE = 5'h01,
        D_RX   = 5'h02,
        D_ACK  = 5'h04,
        D_TX   = 5'h08,
        D_MACK = 5'h10
    } sep_dstate_t;
    typedef enum logic [3:0] {
        H_IDLE  = 4'h1,
        H_START = 4'h2,
        H_BIT   = 4'h4,
        H_STOP  = 4'h8
    } sep_hstate_t;
endpackage : sep_pkg

// [include/sep_bus_if.sv]
// Two-wire bus between the EEPROM slave port and its master.
// Resolves both open-drain lines with a pull-up; enables are active low.
`timescale 1ns/1ps
`default_nettype none
interface sep_bus_if;
    logic scl_host_o;
    logic scl_host_oe_n;
    logic sda_host_o;
    logic sda_host_oe_n;
    logic sda_dev_o;
    logic sda_dev_oe_n;
    logic scl;
    logic sda;
    // Wired-AND with pull-up: a released driver reads as one
    assign scl = scl_host_oe_n | scl_host_o;
    assign sda = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);
    modport dev  (input scl, sda, output sda_dev_o, sda_dev_oe_n);
    modport host (input scl, sda,
                  output scl_host_o, scl_host_oe_n, sda_host_o, sda_host_oe_n);
endinterface : sep_bus_if
`default_nettype wire

// [src/sep_pin_filter.sv]
// Synchroniser plus glitch filter for one bus line.
// Assumes an asynchronous pin; output follows only long-stable levels.
`timescale 1ns/1ps
`default_nettype none
module sep_pin_filter #(
    parameter int STABLE_CYC = sep_pkg::NOISE_CYC + 1
) (
    // System
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Line
    input  wire logic pin_i,
    output logic      level_o
);
    localparam logic [3:0] LAST = 4'(STABLE_CYC - 1);
    logic       s1_q;
    logic       s2_q;
    logic       lvl_q;
    logic [3:0] cnt_q;
    wire        differ = s2_q != lvl_q;
    wire        accept = differ && cnt_q == LAST;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            lvl_q <= 1'b1;
            cnt_q <= 4'h0;
        end else begin
            s1_q  <= pin_i;
            s2_q  <= s1_q;
            lvl_q <= accept ? s2_q : lvl_q;
            cnt_q <= (differ && !accept) ? cnt_q + 4'h1 : 4'h0;
        end
    end
    assign level_o = lvl_q;
endmodule : sep_pin_filter
`default_nettype wire

// [src/sep_eeprom_dev.sv]
// Slave end: two-wire port of a 256-byte serial EEPROM with byte write.
// Assumes rst_i stands for power-on reset and the master owns SCL.
//
// Overview of operation
// - Reset gives standby; supply loss resets again
// - Commands served only after power-up delay
// - Pulses up to 100 ns filtered out
// - SDA open drain: pull low, release high
// - Sample on SCL rise, change after fall
// - SDA change during SCL high is condition
// - SDA fall, SCL high: START; wait for it
// - SDA rise, SCL high: STOP; commit write
// - Slave address upper nibble must be 1010
// - Next three bits match select pins
// - Address LSB one reads, zero writes
// - Matching address acked in ninth clock
// - Word address and data bytes acked
// - Read bytes out, release ninth, continue on ack
// - Master ends read with NoACK then STOP
// - Byte write: address, word, data, STOP
// - No ack during internal write time
// - Master clocks bus, starts only when idle
// - Write protect high refuses writes
// - Protect sampled at fall before data byte
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_dev #(
    parameter int PU_CYC = sep_pkg::POWERUP_READY_DELAY_CYC,
    parameter int WR_CYC = sep_pkg::INTERNAL_WRITE_TIME_CYC
) (
    // System
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Two-wire bus
    sep_bus_if.dev    bus,
    // Straps, pulled down outside when undriven
    input  wire logic addr_select_bit0_i,
    input  wire logic addr_select_bit1_i,
    input  wire logic addr_select_bit2_i,
    input  wire logic wp_i,
    // Status
    output logic      ready_o,
    output logic      busy_o
);
    localparam int W = sep_pkg::CNT_W;

    sep_pkg::sep_dstate_t   state_q;
    sep_pkg::sep_kind_t     kind_q;
    logic [7:0]             mem_q [sep_pkg::MEM_SIZE];
    logic [3:0]             pin_s1_q;
    logic [3:0]             pin_s2_q;
    logic                   scl_f;
    logic                   sda_f;
    logic                   scl_p_q;
    logic                   sda_p_q;
    logic [3:0]             cnt_q;
    logic [7:0]             sh_q;
    logic                   rw_q;
    logic [7:0]             addr_q;
    logic [7:0]             wadr_q;
    logic [7:0]             wdat_q;
    logic                   wpend_q;
    logic                   wp_lat_q;
    logic                   low_q;
    logic                   mack_q;
    logic                   ready_q;
    logic                   busy_q;
    logic [W-1:0]           pu_cnt_q;
    logic [W-1:0]           wr_cnt_q;

    // Glitch filters on both lines
    sep_pin_filter u_scl_filt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (bus.scl),
        .level_o (scl_f)
    );
    sep_pin_filter u_sda_filt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (bus.sda),
        .level_o (sda_f)
    );

    // Bus events
    wire scl_rise = scl_f && !scl_p_q;
    wire scl_fall = !scl_f && scl_p_q;
    wire both_hi  = scl_f && scl_p_q;
    wire start_c  = both_hi && sda_p_q && !sda_f;
    wire stop_c   = both_hi && !sda_p_q && sda_f;
    wire [2:0] sel_pins = pin_s2_q[2:0];
    wire wp_s     = pin_s2_q[3];
    wire nine_end = scl_fall && cnt_q == sep_pkg::ACK_POS;

    // Acknowledge decision for the byte just received
    wire sla_hit  = sh_q[7:4] == sep_pkg::DEV_TYPE
                 && sh_q[3:1] == sel_pins
                 && !busy_q;
    wire ack_ok   = (kind_q == sep_pkg::K_SLA)  ? sla_hit :
                    (kind_q == sep_pkg::K_WORD) ? 1'b1 :
                    !wp_lat_q;
    wire [7:0] rd_byte = mem_q[addr_q];
    wire commit   = stop_c && wpend_q && !busy_q;

    // Straps come from pins: two flip-flops before use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
        end else begin
            pin_s1_q <= {wp_i, addr_select_bit2_i, addr_select_bit1_i,
                         addr_select_bit0_i};
            pin_s2_q <= pin_s1_q;
            scl_p_q  <= scl_f;
            sda_p_q  <= sda_f;
        end
    end

    // Power-up delay; reset puts the port in standby
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_q  <= 1'b0;
            pu_cnt_q <= W'(PU_CYC - 1);
        end else if (!ready_q) begin
            ready_q  <= pu_cnt_q == '0;
            pu_cnt_q <= (pu_cnt_q == '0) ? pu_cnt_q : pu_cnt_q - W'(1);
        end
    end

    // Self-timed internal write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q   <= 1'b0;
            wr_cnt_q <= '0;
        end else if (commit) begin
            busy_q   <= 1'b1;
            wr_cnt_q <= W'(WR_CYC - 1);
        end else if (busy_q) begin
            busy_q   <= wr_cnt_q != '0;
            wr_cnt_q <= (wr_cnt_q == '0) ? wr_cnt_q : wr_cnt_q - W'(1);
        end
    end

    // Array has no reset: contents survive only as data, not control
    always_ff @(posedge clk_i) begin
        if (commit) begin
            mem_q[wadr_q] <= wdat_q;
        end
    end

    // Protocol engine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q  <= sep_pkg::D_IDLE;
            kind_q   <= sep_pkg::K_SLA;
            cnt_q    <= 4'h0;
            sh_q     <= 8'h00;
            rw_q     <= 1'b0;
            addr_q   <= 8'h00;
            wadr_q   <= 8'h00;
            wdat_q   <= 8'h00;
            wpend_q  <= 1'b0;
            wp_lat_q <= 1'b0;
            low_q    <= 1'b0;
            mack_q   <= 1'b0;
        end else if (start_c && ready_q) begin
            state_q <= sep_pkg::D_RX;
            kind_q  <= sep_pkg::K_SLA;
            cnt_q   <= 4'h0;
            low_q   <= 1'b0;
            wpend_q <= 1'b0;
        end else if (stop_c) begin
            state_q <= sep_pkg::D_IDLE;
            low_q   <= 1'b0;
            wpend_q <= 1'b0;
        end else begin
            case (state_q)
                sep_pkg::D_RX: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_f};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (nine_end) begin
                        state_q <= ack_ok ? sep_pkg::D_ACK
                                          : sep_pkg::D_IDLE;
                        low_q   <= ack_ok;
                        if (ack_ok && kind_q == sep_pkg::K_SLA) begin
                            rw_q <= sh_q[0];
                        end
                        if (ack_ok && kind_q == sep_pkg::K_WORD) begin
                            addr_q <= sh_q;
                        end
                        if (ack_ok && kind_q == sep_pkg::K_DATA) begin
                            wadr_q  <= addr_q;
                            wdat_q  <= sh_q;
                            wpend_q <= 1'b1;
                            addr_q  <= addr_q + 8'h01;
                        end
                    end
                end
                sep_pkg::D_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (kind_q == sep_pkg::K_SLA && rw_q) begin
                            state_q <= sep_pkg::D_TX;
                            sh_q    <= rd_byte;
                            low_q   <= !rd_byte[7];
                            addr_q  <= addr_q + 8'h01;
                        end else begin
                            state_q <= sep_pkg::D_RX;
                            low_q   <= 1'b0;
                            kind_q  <= (kind_q == sep_pkg::K_SLA)
                                       ? sep_pkg::K_WORD : sep_pkg::K_DATA;
                        end
                        if (kind_q == sep_pkg::K_WORD) begin
                            wp_lat_q <= wp_s;
                        end
                    end
                end
                sep_pkg::D_TX: begin
                    if (scl_fall && cnt_q == sep_pkg::LAST_BIT) begin
                        state_q <= sep_pkg::D_MACK;
                        low_q   <= 1'b0;
                    end else if (scl_fall) begin
                        sh_q  <= {sh_q[6:0], 1'b0};
                        low_q <= !sh_q[6];
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                sep_pkg::D_MACK: begin
                    if (scl_rise) begin
                        mack_q <= !sda_f;
                    end else if (scl_fall && mack_q) begin
                        state_q <= sep_pkg::D_TX;
                        cnt_q   <= 4'h0;
                        sh_q    <= rd_byte;
                        low_q   <= !rd_byte[7];
                        addr_q  <= addr_q + 8'h01;
                    end else if (scl_fall) begin
                        state_q <= sep_pkg::D_IDLE;
                    end
                end
                default: begin
                    low_q <= 1'b0;
                end
            endcase
        end
    end

    // Open drain: data pin always zero, enable low only to pull low
    assign bus.sda_dev_o    = 1'b0;
    assign bus.sda_dev_oe_n = !low_q;
    assign ready_o          = ready_q;
    assign busy_o           = busy_q;
endmodule : sep_eeprom_dev
`default_nettype wire

// [src/sep_eeprom_host.sv]
// Master end: runs byte writes and single-byte current-address reads
// on the two-wire bus, ordered over a classic Wishbone slave port.
// Assumes the EEPROM end on the same bus and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_host #(
    parameter int QTR_CYC = sep_pkg::QTR_CYC
) (
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Two-wire bus
    sep_bus_if.host          bus
);
    localparam logic [7:0] QLAST = 8'(QTR_CYC - 1);

    sep_pkg::sep_hstate_t state_q;
    logic        scl_s;
    logic        sda_s;
    logic        ack_q;
    logic [31:0] dat_q;
    logic [2:0]  dev_q;
    logic [7:0]  waddr_q;
    logic [7:0]  wdata_q;
    logic [7:0]  rdata_q;
    logic        nack_q;
    logic        go_q;
    logic        rd_q;
    logic [7:0]  qcnt_q;
    logic [1:0]  ph_q;
    logic [8:0]  tx_q;
    logic [3:0]  bit_q;
    logic [1:0]  idx_q;
    logic        scl_low_q;
    logic        sda_low_q;

    // Byte by position in the frame; ninth bit released for ack or NoACK
    function automatic logic [8:0] frame_byte(input logic [1:0] idx);
        frame_byte = (idx == 2'h0) ? {sep_pkg::DEV_TYPE, dev_q, rd_q, 1'b1}
                   : (idx == 2'h1) ? (rd_q ? 9'h1FF : {waddr_q, 1'b1})
                   : {wdata_q, 1'b1};
    endfunction : frame_byte

    sep_pin_filter u_scl_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (bus.scl),
        .level_o (scl_s)
    );
    sep_pin_filter u_sda_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (bus.sda),
        .level_o (sda_s)
    );

    // Register decode
    wire req      = wb_cyc_i && wb_stb_i;
    wire wr_en    = req && wb_we_i && ack_q && wb_sel_i[0];
    wire hit_cmd  = wb_adr_i == sep_pkg::REG_CMD;
    wire hit_dev  = wb_adr_i == sep_pkg::REG_DEVSEL;
    wire hit_wa   = wb_adr_i == sep_pkg::REG_WADDR;
    wire hit_wd   = wb_adr_i == sep_pkg::REG_WDATA;
    wire hit_st   = wb_adr_i == sep_pkg::REG_STATUS;
    wire busy     = state_q != sep_pkg::H_IDLE || go_q;
    wire [31:0] status = {16'h0000, rdata_q, 6'h00, nack_q, busy};
    wire [31:0] rd_mux = hit_dev ? {29'h0, dev_q}
                       : hit_wa  ? {24'h0, waddr_q}
                       : hit_wd  ? {24'h0, wdata_q}
                       : hit_st  ? status : 32'h0;
    wire tick     = qcnt_q == QLAST;
    wire last_idx = idx_q == (rd_q ? 2'h1 : 2'h2);
    wire acked_b  = !(rd_q && idx_q == 2'h1);

    // Wishbone: ack one cycle after the request; write lands with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            dat_q   <= 32'h0;
            dev_q   <= 3'h0;
            waddr_q <= 8'h00;
            wdata_q <= 8'h00;
        end else begin
            ack_q   <= req && !ack_q;
            dat_q   <= rd_mux;
            dev_q   <= (wr_en && hit_dev) ? wb_dat_i[2:0] : dev_q;
            waddr_q <= (wr_en && hit_wa) ? wb_dat_i[7:0] : waddr_q;
            wdata_q <= (wr_en && hit_wd) ? wb_dat_i[7:0] : wdata_q;
        end
    end

    // Bus sequencer, four quarter phases per bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q   <= sep_pkg::H_IDLE;
            go_q      <= 1'b0;
            rd_q      <= 1'b0;
            nack_q    <= 1'b0;
            rdata_q   <= 8'h00;
            qcnt_q    <= 8'h00;
            ph_q      <= 2'h0;
            tx_q      <= 9'h1FF;
            bit_q     <= 4'h0;
            idx_q     <= 2'h0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else begin
            qcnt_q <= (tick || state_q == sep_pkg::H_IDLE)
                      ? 8'h00 : qcnt_q + 8'h01;
            if (tick) begin
                ph_q <= ph_q + 2'h1;
            end
            case (state_q)
                sep_pkg::H_IDLE: begin
                    ph_q <= 2'h0;
                    if (wr_en && hit_cmd && !busy) begin
                        go_q   <= wb_dat_i[sep_pkg::CMD_WR]
                                  | wb_dat_i[sep_pkg::CMD_RD];
                        rd_q   <= wb_dat_i[sep_pkg::CMD_RD];
                        nack_q <= 1'b0;
                    end else if (go_q && scl_s && sda_s) begin
                        go_q    <= 1'b0;
                        state_q <= sep_pkg::H_START;
                        idx_q   <= 2'h0;
                    end
                end
                sep_pkg::H_START: begin
                    if (tick && ph_q == 2'h1) begin
                        sda_low_q <= 1'b1;
                    end else if (tick && ph_q == 2'h3) begin
                        state_q <= sep_pkg::H_BIT;
                        tx_q    <= frame_byte(2'h0);
                        bit_q   <= 4'h0;
                    end
                end
                sep_pkg::H_BIT: begin
                    if (tick && ph_q == 2'h0) begin
                        scl_low_q <= 1'b1;
                    end else if (tick && ph_q == 2'h1) begin
                        sda_low_q <= !tx_q[8];
                    end else if (tick && ph_q == 2'h2) begin
                        scl_low_q <= 1'b0;
                    end else if (tick) begin
                        tx_q  <= {tx_q[7:0], 1'b1};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q != sep_pkg::ACK_POS && !acked_b) begin
                            rdata_q <= {rdata_q[6:0], sda_s};
                        end
                        if (bit_q == sep_pkg::ACK_POS) begin
                            bit_q <= 4'h0;
                            idx_q <= idx_q + 2'h1;
                            tx_q  <= frame_byte(idx_q + 2'h1);
                            if ((acked_b && sda_s) || last_idx) begin
                                state_q <= sep_pkg::H_STOP;
                                nack_q  <= acked_b && sda_s;
                            end
                        end
                    end
                end
                sep_pkg::H_STOP: begin
                    if (tick && ph_q == 2'h0) begin
                        scl_low_q <= 1'b1;
                    end else if (tick && ph_q == 2'h1) begin
                        sda_low_q <= 1'b1;
                    end else if (tick && ph_q == 2'h2) begin
                        scl_low_q <= 1'b0;
                    end else if (tick) begin
                        sda_low_q <= 1'b0;
                        state_q   <= sep_pkg::H_IDLE;
                    end
                end
                default: begin
                    state_q <= sep_pkg::H_IDLE;
                end
            endcase
        end
    end

    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = dat_q;
    assign bus.scl_host_o    = 1'b0;
    assign bus.scl_host_oe_n = !scl_low_q;
    assign bus.sda_host_o    = 1'b0;
    assign bus.sda_host_oe_n = !sda_low_q;
endmodule : sep_eeprom_host
`default_nettype wire

// [tb/sep_bus_monitor.sv]
// Checker on the two-wire bus joining the EEPROM ends.
// Assumes the interface signals, sampled in the host clock domain.
`timescale 1ns/1ps
`default_nettype none
module sep_bus_monitor (
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic scl_host_o,
    input wire logic scl_host_oe_n,
    input wire logic sda_host_o,
    input wire logic sda_host_oe_n,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe_n,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_dev_pulls_low: assert property (!sda_dev_oe_n |-> !sda_dev_o)
        else $error("device drives sda high");
    a_host_sda_low: assert property (!sda_host_oe_n |-> !sda_host_o)
        else $error("host drives sda high");
    a_host_scl_low: assert property ($fell(scl) |-> ##[1:120] $rose(scl))
        else $error("scl held low too long");
    a_dev_edge_low: assert property ($changed(sda_dev_oe_n) |-> !scl)
        else $error("device sda moved while scl high");
    a_dev_hold_bit: assert property ($fell(sda_dev_oe_n) |->
        !sda_dev_oe_n throughout (##[1:300] $fell(scl)))
        else $error("device released sda within its bit");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase too short");
    a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low phase too short");
    a_idle_reset: assert property ($fell(rst_i) |-> scl && sda)
        else $error("bus not idle after reset");
endmodule : sep_bus_monitor
`default_nettype wire

// [tb/serial_eeprom_i2c_slave_port_tb_top.sv]
// Testbench: host and EEPROM ends joined on one two-wire bus.
// Assumes short power-up and write counts set at the instances.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_slave_port_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [2:0]  strap = 3'h0;
    logic        wp    = 1'b0;
    logic [7:0]  wa, d0, d1;
    logic        rdy, bsy;
    logic [63:0] e;
    logic [63:0] exp_q[$];
    int          n_fail = 0, cmp_count = 0, cyc_cnt = 0;
    sep_bus_if bus_i ();
    // Short counts keep the run small; waits below derive from them
    sep_eeprom_dev #(.PU_CYC(400), .WR_CYC(4000)) sep_eeprom_dev_i (
        .clk_i(clk_i), .rst_i(rst_i), .bus(bus_i),
        .addr_select_bit0_i(strap[0]), .addr_select_bit1_i(strap[1]),
        .addr_select_bit2_i(strap[2]), .wp_i(wp), .ready_o(rdy),
        .busy_o(bsy));
    sep_eeprom_host sep_eeprom_host_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .bus(bus_i));
    sep_bus_monitor mon_i (.clk_i(clk_i), .rst_i(rst_i),
        .scl_host_o(bus_i.scl_host_o), .scl_host_oe_n(bus_i.scl_host_oe_n),
        .sda_host_o(bus_i.sda_host_o), .sda_host_oe_n(bus_i.sda_host_oe_n),
        .sda_dev_o(bus_i.sda_dev_o), .sda_dev_oe_n(bus_i.sda_dev_oe_n),
        .scl(bus_i.scl), .sda(bus_i.sda));
    always #25 clk_i = ~clk_i;
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            n_fail++;
            complete_run();
        end
        if (ack && !we && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp_count++;
            if ((rdat & e[63:32]) !== (e[31:0] & e[63:32])) begin
                n_fail++;
                $display("wrong value at %0t: read %h", $time, rdat);
            end
        end
    end
    // Request held until the edge that samples ack, then released
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
        exp_q.push_back({m, x});
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic op(input logic [1:0] c, input logic nk,
                      input logic [7:0] m, b);
        wb(1'b1, sep_pkg::REG_CMD, {30'h0, c});
        do rd(sep_pkg::REG_STATUS, 32'h0, 32'h0);
        while (rdat[sep_pkg::ST_BUSY] !== 1'b0);
        rd(sep_pkg::REG_STATUS, {16'h0, m, 8'h03}, {16'h0, b, 6'h0, nk, 1'b0});
    endtask : op
    task automatic bw(input logic [7:0] a, d);
        wb(1'b1, sep_pkg::REG_WADDR, {24'h0, a});
        wb(1'b1, sep_pkg::REG_WDATA, {24'h0, d});
    endtask : bw
    // Status pins are levels, so they are checked directly
    task automatic chk(input logic v, x);
        cmp_count++;
        if (v !== x) begin
            n_fail++;
            $display("wrong value at %0t: status pin %b", $time, v);
        end
    endtask : chk
    initial begin
        void'($urandom(32'hD4C0));
        strap <= 3'($urandom);
        wa = 8'($urandom);
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, sep_pkg::REG_DEVSEL, {29'h0, strap});
        chk(rdy, 1'b0);
        op(2'h2, 1'b1, 8'h00, 8'h00);
        chk(rdy, 1'b1);
        bw(wa, d0);
        rd(sep_pkg::REG_WDATA, 32'hFF, {24'h0, d0});
        op(2'h1, 1'b0, 8'h00, 8'h00);
        op(2'h2, 1'b1, 8'h00, 8'h00);
        chk(bsy, 1'b1);
        repeat (4100) @(posedge clk_i);
        chk(bsy, 1'b0);
        bw(wa - 8'h01, d1);
        rd(sep_pkg::REG_WADDR, 32'hFF, {24'h0, wa - 8'h01});
        op(2'h1, 1'b0, 8'h00, 8'h00);
        repeat (4100) @(posedge clk_i);
        op(2'h2, 1'b0, 8'hFF, d0);
        wb(1'b1, sep_pkg::REG_DEVSEL, {29'h0, strap ^ 3'h5});
        rd(sep_pkg::REG_DEVSEL, 32'h7, {29'h0, strap ^ 3'h5});
        op(2'h2, 1'b1, 8'h00, 8'h00);
        wb(1'b1, sep_pkg::REG_DEVSEL, {29'h0, strap});
        bw(wa, ~d0);
        wp <= 1'b1;
        op(2'h1, 1'b1, 8'h00, 8'h00);
        op(2'h2, 1'b0, 8'hFF, d0);
        rd(8'hFC, 32'hFFFFFFFF, 32'h0);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(rdy, 1'b0);
        rd(sep_pkg::REG_STATUS, 32'hFFFF, 32'h0);
        // Let the checker take the last read before the verdict
        @(posedge clk_i);
        complete_run();
    end
endmodule : serial_eeprom_i2c_slave_port_tb_top
`default_nettype wire
